/* tb.sv */
// Self-checking testbench for the second channel resource registers.
`timescale 1ns/1ps
`default_nettype none

module tb;
	logic                    core_clk_in;
	logic                    rst_in;
	logic [2:0]              ext_count_in;
	vcr_pkg::vcr_req_type    req_in;
	vcr_pkg::vcr_preset_type preset_in;
	logic                    entry_written_in;
	logic                    negotiating_in;
	logic [31:0]             rdata_out;
	logic                    rvalid_out;
	logic [7:0]              map_out;
	vcr_pkg::vcr_arb_type    arb_select_out;
	logic [2:0]              chan_id_out;
	logic                    channel_enable_out;
	logic                    table_status_out;
	logic                    neg_pending_out;
	logic                    load_busy_out;
	int                      errors;
	int                      checks;
	int                      n;

	vcr_resource_regs vcr_resource_regs_i (
		.core_clk_in                   (core_clk_in),
		.rst_in                        (rst_in),
		.ext_count_in                  (ext_count_in),
		.req_in                        (req_in),
		.preset_in                     (preset_in),
		.entry_written_in              (entry_written_in),
		.negotiating_in                (negotiating_in),
		.rdata_out                     (rdata_out),
		.rvalid_out                    (rvalid_out),
		.traffic_class_channel_map_out (map_out),
		.arb_select_out                (arb_select_out),
		.chan_id_out                   (chan_id_out),
		.channel_enable_out            (channel_enable_out),
		.table_status_out              (table_status_out),
		.neg_pending_out               (neg_pending_out),
		.load_busy_out                 (load_busy_out)
	);

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic step();
		@(posedge core_clk_in);
		#1;
	endtask : step

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("BAD at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic finish_test();
		if (errors == 0 && checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : finish_test

	// An idle cycle follows each access so the strobe is never raised in the step that lowered it.
	task automatic wr(input logic [11:0] addr, input logic [31:0] data, input logic [3:0] be);
		req_in = '{wr: 1'b1, rd: 1'b0, addr: addr, be: be, wdata: data};
		step();
		req_in.wr = 1'b0;
		step();
	endtask : wr

	task automatic rd(input logic [11:0] addr, input logic [31:0] exp);
		req_in = '{wr: 1'b0, rd: 1'b1, addr: addr, be: 4'h0, wdata: 32'h0};
		step();
		req_in.rd = 1'b0;
		chk({31'h0, rvalid_out}, 32'h1);
		chk(rdata_out, exp);
		step();
	endtask : rd

	task automatic do_reset(input logic [2:0] count);
		rst_in = 1'b1;
		ext_count_in = count;
		repeat (16) step();
		rst_in = 1'b0;
		repeat (2) step();
	endtask : do_reset

	initial begin
		core_clk_in = 1'b0;
		forever #2 core_clk_in = ~core_clk_in;
	end

	// The whole sequence needs under a hundred cycles; the limit leaves ample margin.
	initial begin
		#(4 * 3000);
		errors++;
		finish_test();
	end

	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial begin
		errors = 0;
		checks = 0;
		req_in = '0;
		preset_in = '0;
		entry_written_in = 1'b0;
		negotiating_in = 1'b0;
		do_reset(3'h1);
		chk({31'h0, channel_enable_out}, 32'h0);
		chk({31'h0, neg_pending_out}, 32'h0);
		chk({31'h0, table_status_out}, 32'h0);
		chk({29'h0, chan_id_out}, 32'h1);
		rd(12'h15c, 32'h087f0019);
		rd(12'h160, 32'h01000000);
		wr(12'h15c, 32'hffffffff, 4'hf);
		rd(12'h15c, 32'h087f0019);
		rd(12'h164, 32'h0);
		wr(12'h160, 32'hffffffff, 4'h1);
		rd(12'h160, 32'h010000fe);
		entry_written_in = 1'b1;
		step();
		entry_written_in = 1'b0;
		chk({31'h0, table_status_out}, 32'h1);
		wr(12'h160, 32'hffffffff, 4'hf);
		n = 0;
		while (load_busy_out !== 1'b1 && n < 6) begin
			step();
			n++;
		end
		n = 0;
		while (load_busy_out === 1'b1 && n < 20) begin
			step();
			n++;
		end
		chk(n, 32'h8);
		chk({31'h0, table_status_out}, 32'h0);
		rd(12'h160, 32'h870000fe);
		for (int i = 0; i < 8; i++) begin
			wr(12'h160, {i[0], 11'h0, i[2:0], 17'h0}, 4'hf);
			chk({29'h0, arb_select_out}, (i == 0 || i == 3 || i == 4) ? i : 0);
			chk({31'h0, channel_enable_out}, {31'h0, i[0]});
		end
		preset_in = '{valid: 1'b1, slots: 7'h55, map: 8'hff};
		step();
		preset_in.valid = 1'b0;
		step();
		rd(12'h15c, 32'h08550019);
		chk({24'h0, map_out}, 32'hfe);
		negotiating_in = 1'b1;
		repeat (2) step();
		chk({31'h0, neg_pending_out}, 32'h1);
		negotiating_in = 1'b0;
		repeat (2) step();
		chk({31'h0, neg_pending_out}, 32'h0);
		do_reset(3'h0);
		chk({29'h0, chan_id_out}, 32'h0);
		rd(12'h15c, 32'h0);
		rd(12'h160, 32'h0);
		finish_test();
	end
endmodule : tb

`default_nettype wire

/* vcr_pkg.sv */
// Package with offsets, field layout and reset values of the second channel resource registers.
package vcr_pkg;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [11:0] VC1_CAP_OFFSET  = 12'h15c;
	localparam logic [11:0] VC1_CTRL_OFFSET = 12'h160;

	// ----------------------------------------
	// Capability reset values by channel count
	// ----------------------------------------
	localparam logic [7:0] ARB_CAP_ONE      = 8'h19;
	localparam logic [7:0] ARB_CAP_ZERO     = 8'h00;
	localparam logic [6:0] SLOTS_ONE        = 7'h7f;
	localparam logic [6:0] SLOTS_ZERO       = 7'h00;
	localparam logic [7:0] TABLE_OFS_ONE    = 8'h08;
	localparam logic [7:0] TABLE_OFS_ZERO   = 8'h00;
	localparam logic [2:0] CHAN_ID_ONE      = 3'h1;
	localparam logic [2:0] CHAN_ID_ZERO     = 3'h0;
	localparam logic [2:0] EXT_COUNT_ONE    = 3'h1;

	// ----------------------------------------
	// Control field positions and reset values
	// ----------------------------------------
	localparam int          MAP_LSB         = 0;
	localparam int          LOAD_BIT        = 16;
	localparam int          SEL_LSB         = 17;
	localparam int          ID_LSB          = 24;
	localparam int          EN_BIT          = 31;
	localparam logic [7:0]  MAP_RESET       = 8'h00;
	localparam logic [7:0]  MAP_WRITE_MASK  = 8'hfe;
	localparam logic [2:0]  SEL_RESET       = 3'h0;

	// Cycles the table load takes once started.
	localparam logic [3:0]  LOAD_CYCLES     = 4'h8;

	// Arbitration schemes accepted for this channel.
	typedef enum logic [2:0] {
		VCR_ARB_FIXED = 3'h0,
		VCR_ARB_WRR   = 3'h3,
		VCR_ARB_TWRR  = 3'h4
	} vcr_arb_type;

	// Configuration access request.
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [11:0] addr;
		logic [3:0]  be;
		logic [31:0] wdata;
	} vcr_req_type;

	// Presets from SMBus, I2C or EEPROM autoload.
	typedef struct packed {
		logic       valid;
		logic [6:0] slots;
		logic [7:0] map;
	} vcr_preset_type;

endpackage : vcr_pkg

/* vcr_resource_regs.sv */
// Capability and control registers of the second virtual channel resource.
`timescale 1ns/1ps
`default_nettype none

module vcr_resource_regs (
	input  wire logic                 core_clk_in,
	input  wire logic                 rst_in,
	input  wire logic [2:0]           ext_count_in,
	input  wire vcr_pkg::vcr_req_type req_in,
	input  wire vcr_pkg::vcr_preset_type preset_in,
	input  wire logic                 entry_written_in,
	input  wire logic                 negotiating_in,
	output var  logic [31:0]          rdata_out,
	output var  logic                 rvalid_out,
	output var  logic [7:0]           traffic_class_channel_map_out,
	output var  vcr_pkg::vcr_arb_type arb_select_out,
	output var  logic [2:0]           chan_id_out,
	output var  logic                 channel_enable_out,
	output var  logic                 table_status_out,
	output var  logic                 neg_pending_out,
	output var  logic                 load_busy_out
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic                 strap_done;
		logic                 one;
		logic [6:0]           slots;
		logic [7:0]           map;
		vcr_pkg::vcr_arb_type sel;
		logic [2:0]           id;
		logic                 en;
		logic                 load;
		logic [31:0]          rdata;
		logic                 rvalid;
	} vcr_state_type;

	vcr_state_type s_r;
	vcr_state_type s_nxt;
	logic          hit_cap;
	logic          hit_ctrl;
	logic [31:0]   cap_word;
	logic [31:0]   ctrl_word;
	logic          tbl_status;
	logic          neg_pending;
	logic          busy;

	assign hit_cap  = (req_in.addr == vcr_pkg::VC1_CAP_OFFSET);
	assign hit_ctrl = (req_in.addr == vcr_pkg::VC1_CTRL_OFFSET);

	// ----------------------------------------
	// Read words
	// ----------------------------------------
	// The capability word is built from the latched channel count, so it cannot glitch with the strap pin.
	always_comb begin
		cap_word = 32'h0000_0000;
		cap_word[7:0]   = s_r.one ? vcr_pkg::ARB_CAP_ONE : vcr_pkg::ARB_CAP_ZERO;
		cap_word[22:16] = s_r.slots;
		cap_word[31:24] = s_r.one ? vcr_pkg::TABLE_OFS_ONE : vcr_pkg::TABLE_OFS_ZERO;
	end

	always_comb begin
		ctrl_word = 32'h0000_0000;
		ctrl_word[vcr_pkg::MAP_LSB +: 8] = s_r.map;
		ctrl_word[vcr_pkg::SEL_LSB +: 3] = s_r.sel;
		ctrl_word[vcr_pkg::ID_LSB +: 3]  = s_r.id;
		ctrl_word[vcr_pkg::EN_BIT]       = s_r.en;
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		logic [2:0] wsel;
		wsel  = req_in.wdata[vcr_pkg::SEL_LSB +: 3];
		s_nxt = s_r;
		s_nxt.load   = 1'b0;
		s_nxt.rvalid = req_in.rd;
		s_nxt.rdata  = 32'h0000_0000;
		// Channel count is caught once after reset release, as a strap.
		if (!s_r.strap_done) begin
			s_nxt.strap_done = 1'b1;
			s_nxt.one   = (ext_count_in == vcr_pkg::EXT_COUNT_ONE);
			s_nxt.slots = (ext_count_in == vcr_pkg::EXT_COUNT_ONE) ? vcr_pkg::SLOTS_ONE : vcr_pkg::SLOTS_ZERO;
			s_nxt.id    = (ext_count_in == vcr_pkg::EXT_COUNT_ONE) ? vcr_pkg::CHAN_ID_ONE : vcr_pkg::CHAN_ID_ZERO;
		end else if (preset_in.valid) begin
			s_nxt.slots = preset_in.slots;
			s_nxt.map   = preset_in.map & vcr_pkg::MAP_WRITE_MASK;
		end else if (req_in.wr && hit_ctrl) begin
			if (req_in.be[0]) begin
				s_nxt.map = req_in.wdata[7:0] & vcr_pkg::MAP_WRITE_MASK;
			end
			if (req_in.be[2]) begin
				s_nxt.load = req_in.wdata[vcr_pkg::LOAD_BIT];
				unique case (wsel)
					vcr_pkg::VCR_ARB_WRR:  s_nxt.sel = vcr_pkg::VCR_ARB_WRR;
					vcr_pkg::VCR_ARB_TWRR: s_nxt.sel = vcr_pkg::VCR_ARB_TWRR;
					default:               s_nxt.sel = vcr_pkg::VCR_ARB_FIXED;
				endcase
			end
			if (req_in.be[3]) begin
				s_nxt.id = req_in.wdata[vcr_pkg::ID_LSB +: 3];
				s_nxt.en = req_in.wdata[vcr_pkg::EN_BIT];
			end
		end
		if (req_in.rd) begin
			s_nxt.rdata = hit_cap ? cap_word : (hit_ctrl ? ctrl_word : 32'h0000_0000);
		end
	end

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			s_r <= '{strap_done: 1'b0, one: 1'b0, slots: vcr_pkg::SLOTS_ZERO,
				map: vcr_pkg::MAP_RESET, sel: vcr_pkg::VCR_ARB_FIXED, id: vcr_pkg::CHAN_ID_ZERO,
				en: 1'b0, load: 1'b0, rdata: 32'h0000_0000, rvalid: 1'b0};
		end else begin
			s_r <= s_nxt;
		end
	end

	// ----------------------------------------
	// Table loader
	// ----------------------------------------
	vcr_table_loader u_loader (
		.core_clk_in      (core_clk_in),
		.rst_in           (rst_in),
		.entry_written_in (entry_written_in),
		.load_start_in    (s_r.load),
		.negotiating_in   (negotiating_in),
		.table_status_out (tbl_status),
		.neg_pending_out  (neg_pending),
		.load_busy_out    (busy)
	);

	always_comb begin
		rdata_out                     = s_r.rdata;
		rvalid_out                    = s_r.rvalid;
		traffic_class_channel_map_out = s_r.map;
		arb_select_out                = s_r.sel;
		chan_id_out                   = s_r.id;
		channel_enable_out            = s_r.en;
		table_status_out              = tbl_status;
		neg_pending_out               = neg_pending;
		load_busy_out                 = busy;
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_map_bit_zero: assert property (@(posedge core_clk_in) disable iff (rst_in)
		!traffic_class_channel_map_out[0])
		else $error("traffic class zero mapped");
	a_cap_reserved: assert property (@(posedge core_clk_in) disable iff (rst_in)
		s_r.rvalid && $past(req_in.rd && hit_cap) |-> rdata_out[15:8] == 8'h00 && !rdata_out[23])
		else $error("capability reserved bits set");
	a_cap_value: assert property (@(posedge core_clk_in) disable iff (rst_in)
		s_r.strap_done && s_r.one && req_in.rd && hit_cap |=> rdata_out[7:0] == 8'h19 && rdata_out[31:24] == 8'h08)
		else $error("capability value wrong");
	a_load_reads_zero: assert property (@(posedge core_clk_in) disable iff (rst_in)
		req_in.rd && hit_ctrl |=> !rdata_out[16] && rdata_out[23:20] == 4'h0)
		else $error("load strobe or reserved reads one");
	a_load_starts: assert property (@(posedge core_clk_in) disable iff (rst_in)
		s_r.strap_done && !preset_in.valid && req_in.wr && hit_ctrl && req_in.be[2] && req_in.wdata[16]
		|-> ##2 load_busy_out)
		else $error("table load not started");
	a_sel_legal: assert property (@(posedge core_clk_in) disable iff (rst_in)
		s_r.strap_done && !preset_in.valid && req_in.wr && hit_ctrl && req_in.be[2]
		&& !(req_in.wdata[19:17] inside {3'h0, 3'h3, 3'h4}) |=> arb_select_out == vcr_pkg::VCR_ARB_FIXED)
		else $error("illegal scheme accepted");
	a_enable_write: assert property (@(posedge core_clk_in) disable iff (rst_in)
		s_r.strap_done && !preset_in.valid && req_in.wr && hit_ctrl && req_in.be[3]
		|=> channel_enable_out == $past(req_in.wdata[31]))
		else $error("enable not written");
	a_unmapped_zero: assert property (@(posedge core_clk_in) disable iff (rst_in)
		req_in.rd && !hit_cap && !hit_ctrl |=> rdata_out == 32'h0000_0000)
		else $error("unmapped read not zero");
	a_ctrl_reserved: assert property (@(posedge core_clk_in) disable iff (rst_in)
		req_in.rd && hit_ctrl |=> rdata_out[15:8] == 8'h00 && rdata_out[30:27] == 4'h0)
		else $error("control reserved bits set");
	a_ctrl_readback: assert property (@(posedge core_clk_in) disable iff (rst_in)
		req_in.rd && hit_ctrl |=> rdata_out[7:0] == $past(traffic_class_channel_map_out)
		&& rdata_out[19:17] == $past(arb_select_out) && rdata_out[26:24] == $past(chan_id_out)
		&& rdata_out[31] == $past(channel_enable_out))
		else $error("control read does not match the stored fields");
	a_idle_zero: assert property (@(posedge core_clk_in) disable iff (rst_in)
		!req_in.rd |=> rdata_out == 32'h0000_0000 && !rvalid_out)
		else $error("read data shown without a read");

	// ----------------------------------------
	// Strap and reset values
	// ----------------------------------------
	// The strap cycle ignores bus and preset traffic, so one edge later the pure reset values must show.
	a_one_count: assert property (@(posedge core_clk_in) disable iff (rst_in)
		$rose(s_r.strap_done) |-> s_r.one == ($past(ext_count_in) == 3'h1))
		else $error("channel count not latched");
	a_slots_count: assert property (@(posedge core_clk_in) disable iff (rst_in)
		$rose(s_r.strap_done) |-> s_r.slots == (s_r.one ? 7'h7f : 7'h00))
		else $error("time slots reset value wrong");
	a_id_count: assert property (@(posedge core_clk_in) disable iff (rst_in)
		$rose(s_r.strap_done) |-> chan_id_out == (s_r.one ? 3'h1 : 3'h0))
		else $error("channel identifier reset value wrong");
	a_enable_reset: assert property (@(posedge core_clk_in) disable iff (rst_in)
		$rose(s_r.strap_done) |-> !channel_enable_out && traffic_class_channel_map_out == 8'h00
		&& arb_select_out == vcr_pkg::VCR_ARB_FIXED)
		else $error("control reset value wrong");
	a_cap_zero_count: assert property (@(posedge core_clk_in) disable iff (rst_in)
		s_r.strap_done && !s_r.one && req_in.rd && hit_cap
		|=> rdata_out[7:0] == 8'h00 && rdata_out[31:24] == 8'h00)
		else $error("capability not zero for count zero");

	// ----------------------------------------
	// Control writes
	// ----------------------------------------
	a_map_write: assert property (@(posedge core_clk_in) disable iff (rst_in)
		s_r.strap_done && !preset_in.valid && req_in.wr && hit_ctrl && req_in.be[0]
		|=> traffic_class_channel_map_out == ($past(req_in.wdata[7:0]) & 8'hfe))
		else $error("traffic class map not written");
	a_map_hold: assert property (@(posedge core_clk_in) disable iff (rst_in)
		!(req_in.wr && hit_ctrl && req_in.be[0]) && !preset_in.valid |=> $stable(traffic_class_channel_map_out))
		else $error("traffic class map changed without a write");
	a_sel_write: assert property (@(posedge core_clk_in) disable iff (rst_in)
		s_r.strap_done && !preset_in.valid && req_in.wr && hit_ctrl && req_in.be[2]
		&& req_in.wdata[19:17] inside {3'h0, 3'h3, 3'h4} |=> arb_select_out == $past(req_in.wdata[19:17]))
		else $error("legal scheme not stored");
	a_sel_hold: assert property (@(posedge core_clk_in) disable iff (rst_in)
		!(req_in.wr && hit_ctrl && req_in.be[2]) |=> $stable(arb_select_out))
		else $error("scheme changed without a write");
	a_id_write: assert property (@(posedge core_clk_in) disable iff (rst_in)
		s_r.strap_done && !preset_in.valid && req_in.wr && hit_ctrl && req_in.be[3]
		|=> chan_id_out == $past(req_in.wdata[26:24]))
		else $error("channel identifier not written");
	a_enable_hold: assert property (@(posedge core_clk_in) disable iff (rst_in)
		!(req_in.wr && hit_ctrl && req_in.be[3]) |=> $stable(channel_enable_out))
		else $error("enable changed without a write");
	a_write_ignored: assert property (@(posedge core_clk_in) disable iff (rst_in)
		s_r.strap_done && !preset_in.valid && req_in.wr && !hit_ctrl
		|=> $stable(chan_id_out) && $stable(channel_enable_out) && $stable(arb_select_out))
		else $error("write outside the control word took effect");
	a_load_pulse: assert property (@(posedge core_clk_in) disable iff (rst_in)
		!(s_r.strap_done && !preset_in.valid && req_in.wr && hit_ctrl && req_in.be[2] && req_in.wdata[16])
		|=> !s_r.load)
		else $error("table load strobe without a write");

	// ----------------------------------------
	// Presets
	// ----------------------------------------
	a_preset_slots: assert property (@(posedge core_clk_in) disable iff (rst_in)
		s_r.strap_done && preset_in.valid |=> s_r.slots == $past(preset_in.slots))
		else $error("time slots preset not applied");
	a_slots_hold: assert property (@(posedge core_clk_in) disable iff (rst_in)
		s_r.strap_done && !preset_in.valid |=> $stable(s_r.slots))
		else $error("time slots changed without a preset");
	a_preset_map: assert property (@(posedge core_clk_in) disable iff (rst_in)
		s_r.strap_done && preset_in.valid
		|=> traffic_class_channel_map_out == ($past(preset_in.map) & 8'hfe))
		else $error("traffic class map preset not applied");

	// ----------------------------------------
	// Table load and status
	// ----------------------------------------
	// A strobe that lands during a running load is merged into it, so only the length of one load is pinned.
	a_busy_length: assert property (@(posedge core_clk_in) disable iff (rst_in)
		$rose(load_busy_out) |-> load_busy_out[*8] ##1 !load_busy_out)
		else $error("table load length wrong");
	a_status_hold: assert property (@(posedge core_clk_in) disable iff (rst_in)
		table_status_out && !load_busy_out |=> table_status_out)
		else $error("table status cleared outside a load");
	a_pending_clear: assert property (@(posedge core_clk_in) disable iff (rst_in)
		!negotiating_in |=> !neg_pending_out)
		else $error("pending flag not cleared after negotiation");

	// ----------------------------------------
	// Coverage
	// ----------------------------------------
	c_enable: cover property (@(posedge core_clk_in) disable iff (rst_in) $rose(channel_enable_out));
	c_twrr: cover property (@(posedge core_clk_in) disable iff (rst_in) arb_select_out == vcr_pkg::VCR_ARB_TWRR);
	c_preset: cover property (@(posedge core_clk_in) disable iff (rst_in) s_r.strap_done && preset_in.valid);
	c_zero_count: cover property (@(posedge core_clk_in) disable iff (rst_in) $rose(s_r.strap_done) && !s_r.one);

endmodule : vcr_resource_regs

`default_nettype wire

/* vcr_table_loader.sv */
// Table load sequencer and status flags for the second channel.
`timescale 1ns/1ps
`default_nettype none

module vcr_table_loader (
	input  wire logic core_clk_in,
	input  wire logic rst_in,
	input  wire logic entry_written_in,
	input  wire logic load_start_in,
	input  wire logic negotiating_in,
	output var  logic table_status_out,
	output var  logic neg_pending_out,
	output var  logic load_busy_out
);

	typedef enum logic [0:0] {VCR_IDLE, VCR_LOAD} vcr_lstate_type;

	typedef struct packed {
		vcr_lstate_type st;
		logic [3:0]     cnt;
		logic           status;
		logic           pending;
	} vcr_loader_type;

	vcr_loader_type s_r;
	vcr_loader_type s_nxt;

	always_comb begin
		s_nxt = s_r;
		s_nxt.pending = negotiating_in;
		unique case (s_r.st)
			VCR_IDLE: begin
				if (load_start_in) begin
					s_nxt.st  = VCR_LOAD;
					s_nxt.cnt = vcr_pkg::LOAD_CYCLES;
				end
			end
			VCR_LOAD: begin
				s_nxt.cnt = s_r.cnt - 4'h1;
				if (s_r.cnt == 4'h1) begin
					s_nxt.st     = VCR_IDLE;
					s_nxt.status = 1'b0;
				end
			end
		endcase
		// A write to an entry in the finishing cycle still marks the table dirty.
		if (entry_written_in) begin
			s_nxt.status = 1'b1;
		end
	end

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			s_r <= '{st: VCR_IDLE, cnt: 4'h0, status: 1'b0, pending: 1'b0};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign table_status_out = s_r.status;
	assign neg_pending_out  = s_r.pending;
	assign load_busy_out    = (s_r.st == VCR_LOAD);

	a_load_clears: assert property (@(posedge core_clk_in) disable iff (rst_in)
		(s_r.st == VCR_IDLE && load_start_in && !entry_written_in)
		##1 (!entry_written_in)[*8] |=> !table_status_out)
		else $error("table status not cleared after load");
	a_entry_sets: assert property (@(posedge core_clk_in) disable iff (rst_in)
		entry_written_in |=> table_status_out)
		else $error("table status not set by entry write");
	a_pending_track: assert property (@(posedge core_clk_in) disable iff (rst_in)
		negotiating_in |=> neg_pending_out)
		else $error("pending flag not following negotiation");
	c_load_done: cover property (@(posedge core_clk_in) disable iff (rst_in)
		load_busy_out ##1 !load_busy_out);

endmodule : vcr_table_loader

`default_nettype wire
